/* File: hw/lps_top.sv */
// Lane PLL setup controller: APB slave that programs the device's lane
// PLL, clock, termination, swing and calibration registers over the
// device's serial control port.
// Assumes APB master on pclk and a 3-wire serial port on the device.
//
// Summary of operation
// - Charge pump b: reset B0, write 24.
// - VCO tune a: reset 0C, write 03.
// - VCO tune b: reset 00, write 0D.
// - Power-down b: reset 00, write 02.
// - Varactor b: reset FE, write 8E.
// - Charge pump c: reset 17, write 2A.
// - Varactor c: reset 33, write 78.
// - Varactor d: reset 08, write 06.
// - Clock setup eight: reset 4B, write FF.
// - Termination nine: reset C3, write B7.
//
// Register access over APB was left to the implementer.
`default_nettype none
`include "lps_defs.svh"
module lps_top #(
    parameter int SCLK_HALF = `LPS_SCLK_HALF
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output var  logic [31:0]   prdata,
    output var  logic          pready,
    output var  logic          pslverr,
    output var  logic          spi_sclk,
    output var  logic          spi_csb_n,
    output var  logic          spi_sdio_o,
    output var  logic          spi_sdio_oe,
    input  wire logic          spi_sdio_i
);
    import lps_pkg::*;

    lps_spi_if spi ();

    lps_spi #(
        .HALF (SCLK_HALF)
    ) u_spi (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (spi.engine),
        .sclk    (spi_sclk),
        .csb_n   (spi_csb_n),
        .sdio_o  (spi_sdio_o),
        .sdio_oe (spi_sdio_oe),
        .sdio_in (spi_sdio_i)
    );

    // Address and data of one sequence step.
    function automatic logic [22:0] step_entry(input logic [3:0] i,
                                               input logic swing);
        logic [22:0] e;
        e = 23'h000000;
        unique case (i)
            4'h0: e = {`LPS_DEV_CP_B, `LPS_PRG_CP_B};
            4'h1: e = {`LPS_DEV_VCO_A, `LPS_PRG_VCO_A};
            4'h2: e = {`LPS_DEV_VCO_B, `LPS_PRG_VCO_B};
            4'h3: e = {`LPS_DEV_PD_B, `LPS_PRG_PD_B};
            4'h4: e = {`LPS_DEV_VAR_B, `LPS_PRG_VAR_B};
            4'h5: e = {`LPS_DEV_CP_C, `LPS_PRG_CP_C};
            4'h6: e = {`LPS_DEV_VAR_C, `LPS_PRG_VAR_C};
            4'h7: e = {`LPS_DEV_VAR_D, `LPS_PRG_VAR_D};
            4'h8: e = {`LPS_DEV_CLK_EIGHT, `LPS_PRG_CLK_EIGHT};
            4'h9: e = {`LPS_DEV_TERM_NINE, `LPS_PRG_TERM_NINE};
            4'hA: e = {`LPS_DEV_SWING, 7'h00, swing};
            4'hB: e = {`LPS_DEV_TERM_ONE, 8'h00};
            4'hC: e = {`LPS_DEV_TERM_ONE, 8'h01};
            default: e = 23'h000000;
        endcase
        return e;
    endfunction : step_entry

    // Sequencer and register state.
    lps_seq_type  seq_q, seq_d;
    logic [3:0]   step_q, step_d, last_q, last_d;
    logic         man_q, man_d;
    logic         swing_q, swing_d;
    logic [14:0]  maddr_q, maddr_d;
    logic [7:0]   mdata_q, mdata_d;
    logic         mrd_q, mrd_d;
    logic [7:0]   rdata_q, rdata_d;
    logic         done_q, done_d, mdone_q, mdone_d;
    logic         req_q, req_d;
    logic [31:0]  prdata_q, prdata_d;
    logic         pready_q, pready_d, pslverr_q, pslverr_d;
    logic         wr_acc, setup, mapped, busy;
    logic [22:0]  entry;

    assign setup  = psel && !penable && !pready_q;
    assign wr_acc = psel && penable && pready_q && pwrite;
    assign busy   = (seq_q != SEQ_IDLE);
    assign mapped = (paddr == `LPS_OFS_CTRL) || (paddr == `LPS_OFS_STATUS)
                 || (paddr == `LPS_OFS_MANUAL) || (paddr == `LPS_OFS_RDATA)
                 || (paddr == `LPS_OFS_SWING);
    assign entry  = step_entry(step_q, swing_q);

    // APB answer is prepared in the setup cycle so every bus output is a
    // flop; this costs no wait state since pready rises with penable.
    always_comb begin
        prdata_d  = prdata_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        if (setup) begin
            pready_d  = 1'b1;
            pslverr_d = !mapped;
            prdata_d  = 32'h00000000;
            unique case (paddr)
                `LPS_OFS_STATUS: prdata_d = {29'h00000000, mdone_q,
                                             done_q, busy};
                `LPS_OFS_MANUAL: prdata_d = {mrd_q, 7'h00, mdata_q,
                                             1'b0, maddr_q};
                `LPS_OFS_RDATA:  prdata_d = {24'h000000, rdata_q};
                `LPS_OFS_SWING:  prdata_d = {31'h00000000, swing_q};
                default:         prdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Command decode, sequencing and status. Commands that arrive while
    // a sequence runs are dropped; software must poll busy first.
    always_comb begin
        seq_d   = seq_q;
        step_d  = step_q;
        last_d  = last_q;
        man_d   = man_q;
        swing_d = swing_q;
        maddr_d = maddr_q;
        mdata_d = mdata_q;
        mrd_d   = mrd_q;
        rdata_d = rdata_q;
        done_d  = done_q;
        mdone_d = mdone_q;
        req_d   = 1'b0;
        // Software clears of the sticky flags; a set below wins.
        if (wr_acc && paddr == `LPS_OFS_STATUS) begin
            if (pwdata[`LPS_STAT_DONE]) begin
                done_d = 1'b0;
            end
            if (pwdata[`LPS_STAT_MAN_DONE]) begin
                mdone_d = 1'b0;
            end
        end
        if (wr_acc && paddr == `LPS_OFS_SWING) begin
            swing_d = pwdata[0];
        end
        unique case (seq_q)
            SEQ_IDLE: begin
                if (wr_acc && paddr == `LPS_OFS_CTRL) begin
                    if (pwdata[`LPS_CTRL_SETUP]) begin
                        step_d = 4'h0;
                        last_d = `LPS_STEP_LAST;
                        man_d  = 1'b0;
                        seq_d  = SEQ_ISSUE;
                    end else if (pwdata[`LPS_CTRL_CAL]) begin
                        step_d = `LPS_STEP_CAL_LOW;
                        last_d = `LPS_STEP_LAST;
                        man_d  = 1'b0;
                        seq_d  = SEQ_ISSUE;
                    end
                end else if (wr_acc && paddr == `LPS_OFS_MANUAL) begin
                    maddr_d = pwdata[14:0];
                    mdata_d = pwdata[23:16];
                    mrd_d   = pwdata[`LPS_MAN_READ];
                    man_d   = 1'b1;
                    seq_d   = SEQ_ISSUE;
                end
            end
            SEQ_ISSUE: begin
                req_d = 1'b1;
                seq_d = SEQ_WAIT;
            end
            SEQ_WAIT: begin
                if (spi.ack) begin
                    if (man_q) begin
                        if (mrd_q) begin
                            rdata_d = spi.rdata;
                        end
                        mdone_d = 1'b1;
                        seq_d   = SEQ_IDLE;
                    end else if (step_q == last_q) begin
                        done_d = 1'b1;
                        seq_d  = SEQ_IDLE;
                    end else begin
                        step_d = step_q + 4'h1;
                        seq_d  = SEQ_ISSUE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_q   <= SEQ_IDLE;
            step_q  <= 4'h0;
            last_q  <= 4'h0;
            man_q   <= 1'b0;
            swing_q <= 1'b0;
            maddr_q <= 15'h0000;
            mdata_q <= 8'h00;
            mrd_q   <= 1'b0;
            rdata_q <= 8'h00;
            done_q  <= 1'b0;
            mdone_q <= 1'b0;
            req_q   <= 1'b0;
        end else begin
            seq_q   <= seq_d;
            step_q  <= step_d;
            last_q  <= last_d;
            man_q   <= man_d;
            swing_q <= swing_d;
            maddr_q <= maddr_d;
            mdata_q <= mdata_d;
            mrd_q   <= mrd_d;
            rdata_q <= rdata_d;
            done_q  <= done_d;
            mdone_q <= mdone_d;
            req_q   <= req_d;
        end
    end

    // Frame request toward the serial engine.
    assign spi.req   = req_q;
    assign spi.rd    = man_q && mrd_q;
    assign spi.addr  = man_q ? maddr_q : entry[22:8];
    assign spi.wdata = man_q ? mdata_q : entry[7:0];

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
endmodule : lps_top
`default_nettype wire

/* File: hw/lps_defs.svh */
// Constants for the lane PLL setup controller: device register map,
// mandated values, and the controller's own APB register layout.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef LPS_DEFS_SVH
`define LPS_DEFS_SVH

// Device register addresses on the serial control port.
`define LPS_DEV_CP_B       15'h0294
`define LPS_DEV_VCO_A      15'h0296
`define LPS_DEV_VCO_B      15'h0297
`define LPS_DEV_PD_B       15'h0299
`define LPS_DEV_VAR_B      15'h029A
`define LPS_DEV_CP_C       15'h029C
`define LPS_DEV_VAR_C      15'h029F
`define LPS_DEV_VAR_D      15'h02A0
`define LPS_DEV_CLK_EIGHT  15'h02A4
`define LPS_DEV_SWING      15'h02A5
`define LPS_DEV_TERM_ONE   15'h02A7
`define LPS_DEV_TERM_NINE  15'h02AA

// Device reset values, as the device holds them before setup.
`define LPS_RST_CP_B       8'hB0
`define LPS_RST_VCO_A      8'h0C
`define LPS_RST_VCO_B      8'h00
`define LPS_RST_PD_B       8'h00
`define LPS_RST_VAR_B      8'hFE
`define LPS_RST_CP_C       8'h17
`define LPS_RST_VAR_C      8'h33
`define LPS_RST_VAR_D      8'h08
`define LPS_RST_CLK_EIGHT  8'h4B
`define LPS_RST_SWING      8'h00
`define LPS_RST_TERM_ONE   8'h00
`define LPS_RST_TERM_NINE  8'hC3

// Values the setup sequence writes.
`define LPS_PRG_CP_B       8'h24
`define LPS_PRG_VCO_A      8'h03
`define LPS_PRG_VCO_B      8'h0D
`define LPS_PRG_PD_B       8'h02
`define LPS_PRG_VAR_B      8'h8E
`define LPS_PRG_CP_C       8'h2A
`define LPS_PRG_VAR_C      8'h78
`define LPS_PRG_VAR_D      8'h06
`define LPS_PRG_CLK_EIGHT  8'hFF
`define LPS_PRG_TERM_NINE  8'hB7

// Sequence step numbers: 0..9 config, then swing, cal low, cal high.
`define LPS_STEP_SWING     4'hA
`define LPS_STEP_CAL_LOW   4'hB
`define LPS_STEP_LAST      4'hC

// Controller's own APB registers (byte offsets) and fields.
`define LPS_OFS_CTRL       12'h000
`define LPS_OFS_STATUS     12'h004
`define LPS_OFS_MANUAL     12'h008
`define LPS_OFS_RDATA      12'h00C
`define LPS_OFS_SWING      12'h010
`define LPS_CTRL_SETUP     0
`define LPS_CTRL_CAL       1
`define LPS_STAT_BUSY      0
`define LPS_STAT_DONE      1
`define LPS_STAT_MAN_DONE  2
`define LPS_MAN_READ       31

// Serial frame: 1 direction bit, 15 address bits, 8 data bits.
`define LPS_SPI_BITS       5'd24
`define LPS_SPI_DATA_FIRST 5'd16
`define LPS_SCLK_HALF      4

`endif

/* File: hw/lps_pkg.sv */
// Types shared by the lane PLL setup controller modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package lps_pkg;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_ISSUE, SEQ_WAIT} lps_seq_type;
    typedef enum logic [1:0] {SPI_IDLE, SPI_LOW, SPI_HIGH} lps_spi_type;
    typedef logic [14:0] lps_addr_type;
    typedef logic [7:0]  lps_byte_type;
endpackage : lps_pkg
`default_nettype wire

/* File: hw/lps_spi_if.sv */
// Request and answer bundle between the sequencer and the serial engine.
// Assumes both ends run on the same clock.
`default_nettype none
interface lps_spi_if;
    import lps_pkg::*;
    logic         req;   // One-cycle start pulse.
    logic         rd;    // High for a read access.
    lps_addr_type addr;
    lps_byte_type wdata;
    logic         ack;   // One-cycle pulse when the frame has ended.
    lps_byte_type rdata;
    modport master (output req, rd, addr, wdata, input ack, rdata);
    modport engine (input req, rd, addr, wdata, output ack, rdata);
endinterface : lps_spi_if
`default_nettype wire

/* File: hw/lps_sync.sv */
// Three-flop synchroniser for an asynchronous pin with agreement filter.
// Assumes the pin may change at any time relative to pclk.
`default_nettype none
module lps_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output var  logic level
);
    logic s1_q, s2_q, s3_q, lvl_q, lvl_d;

    // The output only follows once the second and third stages agree.
    always_comb begin
        lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    end

    // The first stage feeds only the second one, to let it settle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            s1_q  <= pin;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level = lvl_q;
endmodule : lps_sync
`default_nettype wire

/* File: hw/lps_spi.sv */
// Serial control port master: one 24-bit frame per request, MSB first.
// Assumes the device samples on rising sclk and drives on falling sclk.
`default_nettype none
`include "lps_defs.svh"
module lps_spi #(
    parameter int HALF = `LPS_SCLK_HALF
) (
    input  wire logic  pclk,
    input  wire logic  presetn,
    lps_spi_if.engine  bus,
    output var  logic  sclk,
    output var  logic  csb_n,
    output var  logic  sdio_o,
    output var  logic  sdio_oe,
    input  wire logic  sdio_in
);
    import lps_pkg::*;
    lps_spi_type st_q, st_d;
    logic [7:0]  cnt_q, cnt_d;
    logic [4:0]  bit_q, bit_d;
    logic [23:0] sh_q, sh_d;
    logic        rd_q, rd_d, ack_q, ack_d, oe_q, oe_d;
    logic        sdio_s;

    lps_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (sdio_in),
        .level   (sdio_s)
    );

    // Read data is sampled late in the high phase, a full period after
    // launch, which is why HALF must cover the synchroniser delay.
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        bit_d = bit_q;
        sh_d = sh_q;
        rd_d = rd_q;
        oe_d = oe_q;
        ack_d = 1'b0;
        unique case (st_q)
            SPI_IDLE: begin
                if (bus.req) begin
                    sh_d  = {bus.rd, bus.addr, bus.wdata};
                    rd_d  = bus.rd;
                    oe_d  = 1'b1;
                    bit_d = 5'd0;
                    cnt_d = 8'(HALF - 1);
                    st_d  = SPI_LOW;
                end
            end
            SPI_LOW: begin
                if (cnt_q == 8'h00) begin
                    cnt_d = 8'(HALF - 1);
                    st_d  = SPI_HIGH;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            SPI_HIGH: begin
                if (cnt_q == 8'h00) begin
                    sh_d  = {sh_q[22:0], sdio_s};
                    cnt_d = 8'(HALF - 1);
                    bit_d = bit_q + 5'd1;
                    if (rd_q && bit_q + 5'd1 == `LPS_SPI_DATA_FIRST) begin
                        oe_d = 1'b0; // Turn the line around for read data.
                    end
                    if (bit_q + 5'd1 == `LPS_SPI_BITS) begin
                        oe_d  = 1'b0;
                        ack_d = 1'b1;
                        st_d  = SPI_IDLE;
                    end else begin
                        st_d = SPI_LOW;
                    end
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q  <= SPI_IDLE;
            cnt_q <= 8'h00;
            bit_q <= 5'd0;
            sh_q  <= 24'h000000;
            rd_q  <= 1'b0;
            oe_q  <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            sh_q  <= sh_d;
            rd_q  <= rd_d;
            oe_q  <= oe_d;
            ack_q <= ack_d;
        end
    end

    assign sclk      = (st_q == SPI_HIGH);
    assign csb_n     = (st_q == SPI_IDLE);
    assign sdio_o    = sh_q[23];
    assign sdio_oe   = oe_q;
    assign bus.ack   = ack_q;
    assign bus.rdata = sh_q[7:0];
endmodule : lps_spi
`default_nettype wire

/* File: verif/lps_dev_model.sv */
// Behavioural model of the device's serial control port and its lane
// PLL setup registers. Assumes 24-bit frames, MSB first, 3-wire data.
`default_nettype none
module lps_dev_model (
    input  wire logic sclk,
    input  wire logic csb_n,
    input  wire logic sdio,
    output var  logic drv_en,
    output var  logic drv_bit,
    output var  logic swing_high
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [logic [14:0]];
    logic [23:0] sh;
    logic [7:0]  rb;
    logic        rw;
    int          cnt;
    int          cal_count;
    logic [14:0] log_q [$];

    // Power-on contents of every modelled register.
    initial begin
        mem[15'h294] = 8'hB0;
        mem[15'h296] = 8'h0C;
        mem[15'h297] = 8'h00;
        mem[15'h299] = 8'h00;
        mem[15'h29A] = 8'hFE;
        mem[15'h29C] = 8'h17;
        mem[15'h29F] = 8'h33;
        mem[15'h2A0] = 8'h08;
        mem[15'h2A4] = 8'h4B;
        mem[15'h2A5] = 8'h00;
        mem[15'h2A7] = 8'h00;
        mem[15'h2AA] = 8'hC3;
        cal_count = 0;
        cnt = 0;
        rw = 1'b0;
        drv_en = 1'b0;
        drv_bit = 1'b0;
        swing_high = 1'b0;
    end

    // A new frame restarts the bit count.
    always @(negedge csb_n) begin
        cnt = 0;
    end

    // Bits are taken on rising sclk; the header fixes direction and data.
    always @(posedge sclk) begin
        if (!csb_n) begin
            sh = {sh[22:0], sdio};
            cnt++;
            if (cnt == 16) begin
                rw = sh[15];
                rb = mem.exists(sh[14:0]) ? mem[sh[14:0]] : 8'h00;
            end
        end
    end

    // Read data leaves after falling sclk, so it is settled at the rise.
    always @(negedge sclk) begin
        if (!csb_n && rw && cnt >= 16 && cnt < 24) begin
            drv_en = 1'b1;
            drv_bit = rb[23 - cnt];
        end
    end

    // Only a whole write frame commits; reserved bits stay zero.
    always @(posedge csb_n) begin
        drv_en = 1'b0;
        if (!sh[23] && cnt == 24 && mem.exists(sh[22:8])) begin
            log_q.push_back(sh[22:8]);
            if (sh[22:8] == 15'h2A7 && !mem[15'h2A7][0] && sh[0]) begin
                cal_count++;
            end
            if (sh[22:8] == 15'h2A5 || sh[22:8] == 15'h2A7) begin
                mem[sh[22:8]] = {7'h00, sh[0]};
            end else begin
                mem[sh[22:8]] = sh[7:0];
            end
            swing_high = mem[15'h2A5][0];
        end
    end
endmodule : lps_dev_model
`default_nettype wire

/* File: verif/lps_top_assertions.sv */
// Protocol checks on the controller's APB and serial pins.
// Assumes binding to lps_top with one clock and async active-low reset.
`default_nettype none
module lps_top_assertions #(
    parameter int SCLK_HALF = 4
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        spi_sclk,
    input wire logic        spi_csb_n,
    input wire logic        spi_sdio_o,
    input wire logic        spi_sdio_oe,
    input wire logic        spi_sdio_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] hi_q, hi_d, bits_q, bits_d;
    logic       sclk_q;
    logic       mapped;

    // Length of the high sclk phase and count of rises in a frame.
    always_comb begin
        hi_d = spi_sclk ? hi_q + 8'h01 : 8'h00;
        bits_d = spi_csb_n ? 8'h00
                           : bits_q + {7'h00, spi_sclk & ~sclk_q};
        mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
    end

    // Counters restart at reset so a frame cut short is not miscounted.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_q <= 8'h00;
            bits_q <= 8'h00;
            sclk_q <= 1'b0;
        end else begin
            hi_q <= hi_d;
            bits_q <= bits_d;
            sclk_q <= spi_sclk;
        end
    end

    p_ready_access: assert property (psel && penable |-> pready)
        else $error("pready missing in access phase");
    p_ready_only: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    p_err_map: assert property (psel && penable && !mapped |->
        pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    p_ok_map: assert property (psel && penable && mapped |-> !pslverr)
        else $error("mapped access refused");
    p_sclk_idle: assert property (spi_csb_n |-> !spi_sclk)
        else $error("sclk high outside a frame");
    p_sclk_half: assert property ($fell(spi_sclk) |->
        hi_q == SCLK_HALF[7:0])
        else $error("sclk high phase has wrong length");
    p_sdio_stable: assert property (spi_sclk |-> $stable(spi_sdio_o))
        else $error("sdio changed while sclk high");
    p_oe_frame: assert property (spi_sdio_oe |-> !spi_csb_n)
        else $error("sdio driven outside a frame");
    p_frame_bits: assert property ($rose(spi_csb_n) |-> bits_q == 8'd24)
        else $error("frame does not hold 24 bits");
    p_csb_gap: assert property ($rose(spi_csb_n) |=> spi_csb_n)
        else $error("frames closer than two cycles");
endmodule : lps_top_assertions

bind lps_top lps_top_assertions #(.SCLK_HALF(SCLK_HALF)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .spi_sclk(spi_sclk),
    .spi_csb_n(spi_csb_n), .spi_sdio_o(spi_sdio_o),
    .spi_sdio_oe(spi_sdio_oe), .spi_sdio_i(spi_sdio_i));
`default_nettype wire

/* File: verif/lps_top_test.sv */
// Self-checking bench: APB tasks drive the controller, a device model
// answers on the serial port. Assumes the default SCLK_HALF of 4.
`default_nettype none
module lps_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        sclk, csb_n, so, soe, sdio, den, dbit, swg, er;
    int          bad_count, tests_run;
    logic [14:0] adr [12] = '{15'h294, 15'h296, 15'h297, 15'h299, 15'h29A,
        15'h29C, 15'h29F, 15'h2A0, 15'h2A4, 15'h2AA, 15'h2A5, 15'h2A7};
    logic [7:0]  rst [12] = '{8'hB0, 8'h0C, 8'h00, 8'h00, 8'hFE, 8'h17,
        8'h33, 8'h08, 8'h4B, 8'hC3, 8'h00, 8'h00};
    logic [7:0]  prg [12] = '{8'h24, 8'h03, 8'h0D, 8'h02, 8'h8E, 8'h2A,
        8'h78, 8'h06, 8'hFF, 8'hB7, 8'h01, 8'h01};

    // An undriven data line shows the inverse so stale bits never match.
    assign sdio = soe ? so : (den ? dbit : ~so);

    lps_top #(.SCLK_HALF(4)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .spi_sclk(sclk),
        .spi_csb_n(csb_n), .spi_sdio_o(so), .spi_sdio_oe(soe),
        .spi_sdio_i(sdio));

    lps_dev_model dev_u (.sclk(sclk), .csb_n(csb_n), .sdio(sdio),
        .drv_en(den), .drv_bit(dbit), .swing_high(swing_dummy_fix));

    logic swing_dummy_fix;
    assign swg = swing_dummy_fix;

    // Free-running 50 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One APB transfer; waits for pready without assuming a latency.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_stat(input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, 12'h004, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 3000);
        chk("status done", 32'h1, 32'(rd[b]));
        apb(1'b1, 12'h004, 32'h6);
    endtask : wait_stat

    task automatic dev_rd(input logic [14:0] a);
        apb(1'b1, 12'h008, {1'b1, 16'h0, a});
        wait_stat(2);
        apb(1'b0, 12'h00C, 32'h0);
    endtask : dev_rd

    task automatic dev_wr(input logic [14:0] a, input logic [7:0] d);
        apb(1'b1, 12'h008, {8'h00, d, 1'b0, a});
        wait_stat(2);
    endtask : dev_wr

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    // A hang counts as a mismatch and ends the run the usual way.
    initial begin
        repeat (40000) @(posedge pclk);
        bad_count++;
        close_out();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        bad_count = 0;
        tests_run = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h004, 32'h0);
        chk("status at reset", 32'h0, rd);
        for (int i = 0; i < 12; i++) begin
            dev_rd(adr[i]);
            chk("reset value", 32'(rst[i]), 32'(rd[7:0]));
        end
        $display("test reset values done");
        dev_u.log_q.delete();
        apb(1'b1, 12'h010, 32'h1);
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk("busy", 32'h1, 32'(rd[0]));
        apb(1'b1, 12'h000, 32'h2);
        wait_stat(1);
        chk("frames", 32'd13, 32'(dev_u.log_q.size()));
        for (int j = 0; j < 13; j++) begin
            chk("order", 32'(adr[j < 12 ? j : 11]), 32'(dev_u.log_q[j]));
        end
        for (int i = 0; i < 12; i++) begin
            chk("programmed", 32'(prg[i]), 32'(dev_u.mem[adr[i]]));
        end
        chk("swing high", 32'h1, 32'(swg));
        chk("calibrations", 32'd1, 32'(dev_u.cal_count));
        $display("test full setup done");
        apb(1'b1, 12'h000, 32'h2);
        wait_stat(1);
        chk("calibrations", 32'd2, 32'(dev_u.cal_count));
        chk("frames", 32'd15, 32'(dev_u.log_q.size()));
        $display("test calibrate done");
        dev_wr(15'h2A5, 8'hFF);
        dev_rd(15'h2A5);
        chk("swing readback", 32'h1, 32'(rd[7:0]));
        dev_wr(15'h2A5, 8'h00);
        chk("swing normal", 32'h0, 32'(swg));
        dev_rd(15'h2AA);
        chk("termination", 32'hB7, 32'(rd[7:0]));
        $display("test manual access done");
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped err", 32'h1, 32'(er));
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, 12'h014, 32'hFFFF_FFFF);
        chk("unmapped write err", 32'h1, 32'(er));
        apb(1'b0, 12'h004, 32'h0);
        chk("status cleared", 32'h0, rd);
        $display("test refusals done");
        close_out();
    end
endmodule : lps_top_test
`default_nettype wire
